/* pkg/pimb_pkg.sv */
package pimb_pkg;

	// register byte addresses on the serial bus
	localparam logic [7:0] ADDR_TOP_EVENT_MASK_A   = 8'h20;
	localparam logic [7:0] ADDR_TOP_EVENT_MASK_B   = 8'h21;
	localparam logic [7:0] ADDR_SWITCHER_EVENT_MASK = 8'h22;

	// reset values of the mask registers
	localparam logic [7:0] TOP_EVENT_MASK_A_RESET   = 8'h90;
	localparam logic [7:0] TOP_EVENT_MASK_B_RESET   = 8'h01;
	localparam logic [7:0] SWITCHER_EVENT_MASK_RESET = 8'hcc;

	// bits of the switcher mask that software may change; the rest read zero
	localparam logic [7:0] SWITCHER_EVENT_MASK_WRITABLE = 8'hdd;

	// value returned for an address outside the bank
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// gate positions in top_event_mask_a
	localparam int POS_POWER_OK_IRQ_GATE       = 7;
	localparam int POS_EXT_CLOCK_IRQ_GATE      = 4;
	localparam int POS_HOT_WARNING_IRQ_GATE    = 2;
	localparam int POS_CURRENT_SAMPLE_IRQ_GATE = 0;

	// gate position in top_event_mask_b
	localparam int POS_REG_RESET_IRQ_GATE = 0;

	// gate positions in switcher_event_mask
	localparam int POS_SW1_FALL_GATE        = 7;
	localparam int POS_SW1_RISE_GATE        = 6;
	localparam int POS_SW1_OVERCURRENT_GATE = 4;
	localparam int POS_SW0_FALL_GATE        = 3;
	localparam int POS_SW0_RISE_GATE        = 2;
	localparam int POS_SW0_OVERCURRENT_GATE = 0;

	// live condition inputs, in order of the raw status vector
	localparam int NUM_LEVELS          = 7;
	localparam int LVL_POWER_OK        = 0;
	localparam int LVL_EXT_CLOCK       = 1;
	localparam int LVL_HOT_WARNING     = 2;
	localparam int LVL_SW0_OUTPUT_OK   = 3;
	localparam int LVL_SW0_OVERCURRENT = 4;
	localparam int LVL_SW1_OUTPUT_OK   = 5;
	localparam int LVL_SW1_OVERCURRENT = 6;

	// interrupt flags
	localparam int NUM_FLAGS            = 9;
	localparam int FLAG_POWER_OK        = 0;
	localparam int FLAG_EXT_CLOCK       = 1;
	localparam int FLAG_HOT_WARNING     = 2;
	localparam int FLAG_CURRENT_SAMPLE  = 3;
	localparam int FLAG_REG_RESET       = 4;
	localparam int FLAG_SW0_OUTPUT_OK   = 5;
	localparam int FLAG_SW0_OVERCURRENT = 6;
	localparam int FLAG_SW1_OUTPUT_OK   = 7;
	localparam int FLAG_SW1_OVERCURRENT = 8;

	// serial slave states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_REG,
		ST_REG_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RACK
	} pimb_serial_state_type;

endpackage

/* hw/pimb_event_gate.sv */
module pimb_event_gate #(
	parameter int W = 7
) (
	// clock, reset, enable
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	// live levels
	input  wire logic [W-1:0] level,
	// one-cycle edge pulses
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	logic [W-1:0] level_q;

	// previous sample; raw conditions idle at zero after reset
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			level_q <= '0;
		end else if (ce) begin
			level_q <= level;
		end
	end

	// registered edge pulses, one cycle each
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rise <= '0;
			fall <= '0;
		end else if (ce) begin
			rise <= level & ~level_q;
			fall <= ~level & level_q;
		end
	end

endmodule

/* hw/pimb_flag_bank.sv */
module pimb_flag_bank #(
	parameter int W = 9
) (
	// clock, reset, enable
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	// unmasked events and clears
	input  wire logic [W-1:0] set_evt,
	input  wire logic [W-1:0] clear,
	// sticky flags
	output logic      [W-1:0] flags
);

	// set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			flags <= '0;
		end else if (ce) begin
			flags <= (flags & ~clear) | set_evt;
		end
	end

endmodule

/* hw/pimb_mask_bank.sv */
module pimb_mask_bank
	import pimb_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDR = 7'h2c // arbitrary bus address
) (
	// clock, reset, enable
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	input  wire logic                  ce,
	// serial bus, open drain data
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe_n,
	// one-time memory value of the register-reset gate
	input  wire logic                  otp_reg_reset_gate,
	// live conditions, 1 = invalid / active
	input  wire logic                  power_ok_raw,
	input  wire logic                  ext_clock_raw,
	input  wire logic                  hot_warning_raw,
	input  wire logic                  sw0_output_ok_raw,
	input  wire logic                  sw0_overcurrent_raw,
	input  wire logic                  sw1_output_ok_raw,
	input  wire logic                  sw1_overcurrent_raw,
	// one-cycle event pulses
	input  wire logic                  current_sample_done,
	input  wire logic                  reg_reset_done,
	// flag clears from the flag registers
	input  wire logic [NUM_FLAGS-1:0]  flag_clear,
	// status and interrupt
	output logic      [NUM_LEVELS-1:0] raw_status,
	output logic      [NUM_FLAGS-1:0]  irq_flags,
	output logic                       irq_n
);

	// mask registers
	logic [7:0] top_event_mask_a;
	logic [7:0] top_event_mask_b;
	logic [7:0] switcher_event_mask;

	// serial slave state
	pimb_serial_state_type state;
	logic [7:0] shifter;
	logic [7:0] pointer;
	logic [2:0] bit_cnt;
	logic       byte_done;
	logic       read_mode;
	logic       master_nack;
	logic       scl_q;
	logic       sda_q;
	logic       wr_strobe;
	logic [7:0] wr_data;

	// bus conditions
	logic       start_cond;
	logic       stop_cond;
	logic       scl_rise;
	logic       scl_fall;
	logic [7:0] read_value;

	// event path
	logic [NUM_LEVELS-1:0] levels;
	logic [NUM_LEVELS-1:0] level_rise;
	logic [NUM_LEVELS-1:0] level_fall;
	logic [NUM_FLAGS-1:0]  flag_set;

	// named gates
	logic power_ok_irq_gate;
	logic ext_clock_irq_gate;
	logic hot_warning_irq_gate;
	logic current_sample_irq_gate;
	logic reg_reset_irq_gate;
	logic sw1_fall_gate;
	logic sw1_rise_gate;
	logic sw1_overcurrent_gate;
	logic sw0_fall_gate;
	logic sw0_rise_gate;
	logic sw0_overcurrent_gate;

	// register read decode, unmapped addresses read a fixed value
	function automatic logic [7:0] pimb_read_value(
		input logic [7:0] addr,
		input logic [7:0] mask_a,
		input logic [7:0] mask_b,
		input logic [7:0] mask_sw
	);
		case (addr)
			ADDR_TOP_EVENT_MASK_A:    return mask_a;
			ADDR_TOP_EVENT_MASK_B:    return mask_b;
			ADDR_SWITCHER_EVENT_MASK: return mask_sw;
			default:                  return UNMAPPED_READ_VALUE;
		endcase
	endfunction

	// write decode against the current register pointer
	function automatic logic pimb_write_hit(
		input logic       strobe,
		input logic [7:0] addr,
		input logic [7:0] target
	);
		return strobe && (addr == target);
	endfunction

	// bus edges from the previous sample; pins are synchronous to core_clk
	assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
	assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
	assign scl_rise   = scl_in & ~scl_q;
	assign scl_fall   = ~scl_in & scl_q;
	assign read_value = pimb_read_value(pointer, top_event_mask_a, top_event_mask_b, switcher_event_mask);

	// previous bus levels; idle bus is high
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce) begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// open drain: the data level is only ever pulled low
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sda_out <= 1'b0;
		end else if (ce) begin
			sda_out <= 1'b0;
		end
	end

	// serial slave: address, register pointer, then data with auto increment
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state       <= ST_IDLE;
			shifter     <= 8'h00;
			pointer     <= 8'h00;
			bit_cnt     <= 3'h0;
			byte_done   <= 1'b0;
			read_mode   <= 1'b0;
			master_nack <= 1'b0;
			sda_oe_n    <= 1'b1;
			wr_strobe   <= 1'b0;
			wr_data     <= 8'h00;
		end else if (ce) begin
			wr_strobe <= 1'b0;
			if (stop_cond) begin
				state    <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end else if (start_cond) begin
				// a repeated start keeps the pointer for a following read
				state     <= ST_ADDR;
				bit_cnt   <= 3'h0;
				byte_done <= 1'b0;
				sda_oe_n  <= 1'b1;
			end else if (scl_rise) begin
				case (state)
					ST_ADDR, ST_REG, ST_WDATA: begin
						shifter   <= {shifter[6:0], sda_in};
						bit_cnt   <= bit_cnt + 3'h1;
						byte_done <= (bit_cnt == 3'h7);
					end
					ST_RDATA: begin
						bit_cnt   <= bit_cnt + 3'h1;
						byte_done <= (bit_cnt == 3'h7);
					end
					ST_RACK: begin
						master_nack <= sda_in;
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				// data changes only while the clock is low
				case (state)
					ST_ADDR: begin
						if (byte_done) begin
							byte_done <= 1'b0;
							if (shifter[7:1] == DEVICE_ADDR) begin
								read_mode <= shifter[0];
								sda_oe_n  <= 1'b0;
								state     <= ST_ADDR_ACK;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					ST_ADDR_ACK: begin
						if (read_mode) begin
							shifter  <= read_value;
							sda_oe_n <= read_value[7];
							bit_cnt  <= 3'h0;
							state    <= ST_RDATA;
						end else begin
							sda_oe_n <= 1'b1;
							state    <= ST_REG;
						end
					end
					ST_REG: begin
						if (byte_done) begin
							byte_done <= 1'b0;
							pointer   <= shifter;
							sda_oe_n  <= 1'b0;
							state     <= ST_REG_ACK;
						end
					end
					ST_REG_ACK: begin
						sda_oe_n <= 1'b1;
						state    <= ST_WDATA;
					end
					ST_WDATA: begin
						if (byte_done) begin
							byte_done <= 1'b0;
							wr_strobe <= 1'b1;
							wr_data   <= shifter;
							sda_oe_n  <= 1'b0;
							state     <= ST_WDATA_ACK;
						end
					end
					ST_WDATA_ACK: begin
						sda_oe_n <= 1'b1;
						pointer  <= pointer + 8'h01;
						state    <= ST_WDATA;
					end
					ST_RDATA: begin
						if (byte_done) begin
							// advance now so the next byte is ready at the ack
							byte_done <= 1'b0;
							sda_oe_n  <= 1'b1;
							pointer   <= pointer + 8'h01;
							state     <= ST_RACK;
						end else begin
							shifter  <= {shifter[6:0], 1'b0};
							sda_oe_n <= shifter[6];
						end
					end
					ST_RACK: begin
						if (master_nack) begin
							state <= ST_IDLE;
						end else begin
							shifter  <= read_value;
							sda_oe_n <= read_value[7];
							bit_cnt  <= 3'h0;
							state    <= ST_RDATA;
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// first top mask; reserved bits are plain storage
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			top_event_mask_a <= TOP_EVENT_MASK_A_RESET;
		end else if (ce && pimb_write_hit(wr_strobe, pointer, ADDR_TOP_EVENT_MASK_A)) begin
			top_event_mask_a <= wr_data;
		end
	end

	// second top mask; the gate bit is refilled from one-time memory on every reset
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			top_event_mask_b <= {TOP_EVENT_MASK_B_RESET[7:1], otp_reg_reset_gate};
		end else if (ce && pimb_write_hit(wr_strobe, pointer, ADDR_TOP_EVENT_MASK_B)) begin
			top_event_mask_b <= wr_data;
		end
	end

	// switcher mask; reserved bits stay zero whatever is written
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			switcher_event_mask <= SWITCHER_EVENT_MASK_RESET;
		end else if (ce && pimb_write_hit(wr_strobe, pointer, ADDR_SWITCHER_EVENT_MASK)) begin
			switcher_event_mask <= wr_data & SWITCHER_EVENT_MASK_WRITABLE;
		end
	end

	// gate bits by name
	assign power_ok_irq_gate       = top_event_mask_a[POS_POWER_OK_IRQ_GATE];
	assign ext_clock_irq_gate      = top_event_mask_a[POS_EXT_CLOCK_IRQ_GATE];
	assign hot_warning_irq_gate    = top_event_mask_a[POS_HOT_WARNING_IRQ_GATE];
	assign current_sample_irq_gate = top_event_mask_a[POS_CURRENT_SAMPLE_IRQ_GATE];
	assign reg_reset_irq_gate      = top_event_mask_b[POS_REG_RESET_IRQ_GATE];
	assign sw1_fall_gate           = switcher_event_mask[POS_SW1_FALL_GATE];
	assign sw1_rise_gate           = switcher_event_mask[POS_SW1_RISE_GATE];
	assign sw1_overcurrent_gate    = switcher_event_mask[POS_SW1_OVERCURRENT_GATE];
	assign sw0_fall_gate           = switcher_event_mask[POS_SW0_FALL_GATE];
	assign sw0_rise_gate           = switcher_event_mask[POS_SW0_RISE_GATE];
	assign sw0_overcurrent_gate    = switcher_event_mask[POS_SW0_OVERCURRENT_GATE];

	// live condition vector
	always_comb begin
		levels                      = '0;
		levels[LVL_POWER_OK]        = power_ok_raw;
		levels[LVL_EXT_CLOCK]       = ext_clock_raw;
		levels[LVL_HOT_WARNING]     = hot_warning_raw;
		levels[LVL_SW0_OUTPUT_OK]   = sw0_output_ok_raw;
		levels[LVL_SW0_OVERCURRENT] = sw0_overcurrent_raw;
		levels[LVL_SW1_OUTPUT_OK]   = sw1_output_ok_raw;
		levels[LVL_SW1_OVERCURRENT] = sw1_overcurrent_raw;
	end

	// raw status follows the conditions, never the masks
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			raw_status <= '0;
		end else if (ce) begin
			raw_status <= levels;
		end
	end

	pimb_event_gate #(
		.W (NUM_LEVELS)
	) u_event_gate (
		.core_clk (core_clk),
		.resetn   (resetn),
		.ce       (ce),
		.level    (levels),
		.rise     (level_rise),
		.fall     (level_fall)
	);

	// an event is gated by the mask value in the cycle it is detected
	always_comb begin
		flag_set = '0;
		flag_set[FLAG_POWER_OK] = (level_rise[LVL_POWER_OK] | level_fall[LVL_POWER_OK])
			& ~power_ok_irq_gate;
		flag_set[FLAG_EXT_CLOCK] = (level_rise[LVL_EXT_CLOCK] | level_fall[LVL_EXT_CLOCK])
			& ~ext_clock_irq_gate;
		flag_set[FLAG_HOT_WARNING]     = level_rise[LVL_HOT_WARNING] & ~hot_warning_irq_gate;
		flag_set[FLAG_CURRENT_SAMPLE]  = current_sample_done & ~current_sample_irq_gate;
		flag_set[FLAG_REG_RESET]       = reg_reset_done & ~reg_reset_irq_gate;
		// raw rising means output became invalid, falling means valid
		flag_set[FLAG_SW1_OUTPUT_OK] = (level_rise[LVL_SW1_OUTPUT_OK] & ~sw1_fall_gate)
			| (level_fall[LVL_SW1_OUTPUT_OK] & ~sw1_rise_gate);
		flag_set[FLAG_SW0_OUTPUT_OK] = (level_rise[LVL_SW0_OUTPUT_OK] & ~sw0_fall_gate)
			| (level_fall[LVL_SW0_OUTPUT_OK] & ~sw0_rise_gate);
		flag_set[FLAG_SW1_OVERCURRENT] = level_rise[LVL_SW1_OVERCURRENT] & ~sw1_overcurrent_gate;
		flag_set[FLAG_SW0_OVERCURRENT] = level_rise[LVL_SW0_OVERCURRENT] & ~sw0_overcurrent_gate;
	end

	pimb_flag_bank #(
		.W (NUM_FLAGS)
	) u_flag_bank (
		.core_clk (core_clk),
		.resetn   (resetn),
		.ce       (ce),
		.set_evt  (flag_set),
		.clear    (flag_clear),
		.flags    (irq_flags)
	);

	// flags are only ever set by unmasked events, so any flag drives the output
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			irq_n <= 1'b1;
		end else if (ce) begin
			irq_n <= ~(|irq_flags);
		end
	end

endmodule

/* verification/pimb_mask_bank_properties.sv */
module pimb_mask_bank_properties
	import pimb_pkg::*;
(
	// clock and reset
	input wire logic                  core_clk,
	input wire logic                  resetn,
	// live conditions and pulses
	input wire logic                  power_ok_raw,
	input wire logic                  ext_clock_raw,
	input wire logic                  hot_warning_raw,
	input wire logic                  sw0_output_ok_raw,
	input wire logic                  sw0_overcurrent_raw,
	input wire logic                  sw1_output_ok_raw,
	input wire logic                  sw1_overcurrent_raw,
	input wire logic                  current_sample_done,
	input wire logic                  reg_reset_done,
	input wire logic [NUM_FLAGS-1:0]  flag_clear,
	// status and interrupt
	input wire logic [NUM_LEVELS-1:0] raw_status,
	input wire logic [NUM_FLAGS-1:0]  irq_flags,
	input wire logic                  irq_n
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire logic [NUM_LEVELS-1:0] lvl = {sw1_overcurrent_raw, sw1_output_ok_raw, sw0_overcurrent_raw,
		sw0_output_ok_raw, hot_warning_raw, ext_clock_raw, power_ok_raw};
	// two quiet cycles of flags
	sequence quiet_s;
		(irq_flags == '0) [*2];
	endsequence
	// a raw change seen one cycle late, either direction
	sequence moved_s(int i);
		$past(raw_status[i]) != $past(raw_status[i], 2);
	endsequence
	// a raw rise seen one cycle late
	sequence rose_s(int i);
		$past(raw_status[i]) && !$past(raw_status[i], 2);
	endsequence
	raw_follow_a: assert property (1'b1 |=> raw_status == $past(lvl))
		else $error("raw status does not follow live levels");
	irq_raise_a: assert property ((|irq_flags) |=> !irq_n)
		else $error("flag set but interrupt not active");
	irq_release_a: assert property (quiet_s |-> irq_n)
		else $error("interrupt active with no flag");
	flag_sticky_a: assert property ($past(resetn) |-> ($past(irq_flags) & ~irq_flags & ~$past(flag_clear)) == '0)
		else $error("flag dropped without clear");
	power_ok_cause_a: assert property ($rose(irq_flags[FLAG_POWER_OK]) |-> moved_s(0))
		else $error("power flag without edge");
	ext_clock_cause_a: assert property ($rose(irq_flags[FLAG_EXT_CLOCK]) |-> moved_s(1))
		else $error("clock flag without edge");
	hot_warn_cause_a: assert property ($rose(irq_flags[FLAG_HOT_WARNING]) |-> rose_s(2))
		else $error("thermal flag without rise");
	sample_cause_a: assert property ($rose(irq_flags[FLAG_CURRENT_SAMPLE]) |-> $past(current_sample_done))
		else $error("sample flag without pulse");
	reg_reset_cause_a: assert property ($rose(irq_flags[FLAG_REG_RESET]) |-> $past(reg_reset_done))
		else $error("reset flag without pulse");
	sw0_ok_cause_a: assert property ($rose(irq_flags[FLAG_SW0_OUTPUT_OK]) |-> moved_s(3))
		else $error("switcher 0 flag without edge");
	sw1_ok_cause_a: assert property ($rose(irq_flags[FLAG_SW1_OUTPUT_OK]) |-> moved_s(5))
		else $error("switcher 1 flag without edge");
	sw0_oc_cause_a: assert property ($rose(irq_flags[FLAG_SW0_OVERCURRENT]) |-> rose_s(4))
		else $error("switcher 0 limit flag without rise");
	sw1_oc_cause_a: assert property ($rose(irq_flags[FLAG_SW1_OVERCURRENT]) |-> rose_s(6))
		else $error("switcher 1 limit flag without rise");
endmodule

bind pimb_mask_bank pimb_mask_bank_properties chk (
	.core_clk(core_clk), .resetn(resetn), .power_ok_raw(power_ok_raw), .ext_clock_raw(ext_clock_raw),
	.hot_warning_raw(hot_warning_raw), .sw0_output_ok_raw(sw0_output_ok_raw),
	.sw0_overcurrent_raw(sw0_overcurrent_raw), .sw1_output_ok_raw(sw1_output_ok_raw),
	.sw1_overcurrent_raw(sw1_overcurrent_raw), .current_sample_done(current_sample_done),
	.reg_reset_done(reg_reset_done), .flag_clear(flag_clear), .raw_status(raw_status),
	.irq_flags(irq_flags), .irq_n(irq_n)
);

/* verification/pimb_host_model.sv */
module pimb_host_model #(
	parameter logic [6:0] DEV = 7'h2c // arbitrary, same as the device default
) (
	// clock
	input  wire logic       core_clk,
	// serial bus, data is the resolved wire
	input  wire logic       sda_bus,
	output logic            scl,
	output logic            sda_drv,
	// read results
	output logic            rd_stb,
	output logic      [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 100ps;
	int half = 3; // cycles per clock phase; larger makes a slow host
	// idle bus: clock stands high, data released
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		rd_stb = 1'b0;
		rd_data = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// data only moves two cycles after clock falls, so it never mimics start or stop
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		tick(half);
		scl = 1'b1;
		tick(half);
		r = sda_bus;
		scl = 1'b0;
		tick(2);
	endtask
	task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic k);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(last, k);
	endtask
	task automatic start();
		sda_drv = 1'b1;
		tick(half);
		scl = 1'b1;
		tick(half);
		sda_drv = 1'b0;
		tick(half);
		scl = 1'b0;
		tick(2);
	endtask
	task automatic stop();
		sda_drv = 1'b0;
		tick(half);
		scl = 1'b1;
		tick(half);
		sda_drv = 1'b1;
		tick(half);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] rx;
		logic       k;
		start();
		byte_io({DEV, 1'b0}, 1'b1, rx, k);
		byte_io(a, 1'b1, rx, k);
		byte_io(d, 1'b1, rx, k);
		stop();
	endtask
	// pointer set, repeated start, one byte read and refused with a nack
	task automatic rd(input logic [7:0] a);
		logic [7:0] rx;
		logic       k;
		start();
		byte_io({DEV, 1'b0}, 1'b1, rx, k);
		byte_io(a, 1'b1, rx, k);
		start();
		byte_io({DEV, 1'b1}, 1'b1, rx, k);
		byte_io(8'hff, 1'b1, rx, k);
		stop();
		rd_data = rx;
		rd_stb = 1'b1;
		tick(1);
		rd_stb = 1'b0;
	endtask
endmodule

/* verification/pimb_mask_bank_bench.sv */
module pimb_mask_bank_bench
	import pimb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// stimulus and observed signals
	logic                  core_clk = 1'b0;
	logic                  resetn = 1'b0;
	logic                  otp = 1'b1;
	logic [6:0]            lv = 7'h00;
	logic                  cs_done = 1'b0;
	logic                  rr_done = 1'b0;
	logic [8:0]            clr = 9'h000;
	logic                  scl;
	logic                  sda_drv;
	logic                  sda_out;
	logic                  sda_oe_n;
	logic                  rd_stb;
	logic [7:0]            rd_data;
	logic [NUM_LEVELS-1:0] raw_status;
	logic [NUM_FLAGS-1:0]  irq_flags;
	logic                  irq_n;
	int                    err_total = 0;
	int                    compares = 0;
	logic [7:0]            exp_q[$];
	// pull-up wire: low when either side pulls
	wire sda_bus = sda_drv & (sda_oe_n | sda_out);
	// events: level (-1 pulse), start level, register offset, gate bit, flag
	int c_lvl[11] = '{0, 1, 2, -1, -1, 3, 3, 4, 5, 5, 6};
	int c_pre[11] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 1, 0};
	int c_reg[11] = '{0, 0, 0, 0, 1, 2, 2, 2, 2, 2, 2};
	int c_bit[11] = '{7, 4, 2, 0, 0, 3, 2, 0, 7, 6, 4};
	int c_flg[11] = '{0, 1, 2, 3, 4, 5, 5, 6, 7, 7, 8};
	always #4 core_clk = ~core_clk;
	pimb_mask_bank DUT (
		.core_clk(core_clk), .resetn(resetn), .ce(1'b1), .scl_in(scl), .sda_in(sda_bus),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .otp_reg_reset_gate(otp),
		.power_ok_raw(lv[0]), .ext_clock_raw(lv[1]), .hot_warning_raw(lv[2]), .sw0_output_ok_raw(lv[3]),
		.sw0_overcurrent_raw(lv[4]), .sw1_output_ok_raw(lv[5]), .sw1_overcurrent_raw(lv[6]),
		.current_sample_done(cs_done), .reg_reset_done(rr_done), .flag_clear(clr),
		.raw_status(raw_status), .irq_flags(irq_flags), .irq_n(irq_n)
	);
	pimb_host_model host (
		.core_clk(core_clk), .sda_bus(sda_bus), .scl(scl), .sda_drv(sda_drv), .rd_stb(rd_stb), .rd_data(rd_data)
	);
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		compares++;
		if (seen !== want) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.rd(a);
	endtask
	// close every gate so setup edges leave no flag
	task automatic shut();
		for (int r = 0; r < 3; r++) host.wr(8'h20 + 8'(r), 8'hff);
	endtask
	task automatic conclude();
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// each read result meets the oldest expectation
	always @(posedge core_clk) begin
		if (rd_stb === 1'b1) check(rd_data, exp_q.pop_front());
	end
	// a hung sequence must not stall the run
	initial begin
		repeat (90000) @(posedge core_clk);
		err_total++;
		conclude();
	end
	initial begin
		logic [7:0] v[5];
		void'($urandom(32'h2d238468));
		step(16);
		resetn = 1'b1;
		rd(8'h20, 8'h90);
		rd(8'h21, 8'h01);
		rd(8'h22, 8'hcc);
		// random bytes over the bank and both neighbours; reserved switcher bits always tried
		for (int i = 0; i < 5; i++) begin
			v[i] = 8'($urandom) | ((i == 3) ? 8'h22 : 8'h00);
			host.wr(8'h1f + 8'(i), v[i]);
		end
		rd(8'h1f, 8'h00);
		rd(8'h20, v[1]);
		rd(8'h21, v[2]);
		rd(8'h22, v[3] & 8'hdd);
		rd(8'h23, 8'h00);
		// the register-reset gate reloads from one-time memory, a host write does not last
		otp = 1'b0;
		host.wr(8'h21, 8'hff);
		resetn = 1'b0;
		step(2);
		resetn = 1'b1;
		rd(8'h21, 8'h00);
		rd(8'h20, 8'h90);
		// each source with its gate open, then shut: flag, interrupt, raw status
		for (int c = 0; c < 11; c++) begin
			for (int m = 0; m < 2; m++) begin
				shut();
				if (c_lvl[c] >= 0) lv[c_lvl[c]] = c_pre[c][0];
				step(4);
				clr = 9'h1ff;
				step(1);
				clr = 9'h000;
				if (m == 0) host.wr(8'h20 + 8'(c_reg[c]), ~(8'h01 << c_bit[c]));
				if (c_lvl[c] >= 0) lv[c_lvl[c]] = ~c_pre[c][0];
				else if (c_flg[c] == 3) cs_done = 1'b1;
				else rr_done = 1'b1;
				step(1);
				cs_done = 1'b0;
				rr_done = 1'b0;
				step(3);
				check(irq_flags, (m != 0) ? 16'h0000 : 16'h0001 << c_flg[c]);
				check(irq_n, m[0]);
				check(raw_status, lv);
				shut();
				lv = 7'h00;
				step(4);
				clr = 9'h1ff;
				step(1);
				clr = 9'h000;
				step(2);
				check(irq_n, 1'b1);
			end
		end
		step(4);
		if (exp_q.size() != 0) err_total++;
		conclude();
	end
endmodule
